// ==== hw/strap_config_decoder.sv ====
`include "strap_params.svh"
`default_nettype none
// Behaviour
// - interface group low selects three-pin serial
// - group high selects parallel, style picks strobes
// - width straps give 8, 16, 9, 18 bits
// - reset input is active low
// - extended commands accepted only while strap high
// - open extended strap reads low, blocked
// - line straps give 220, 176, reserved, 132
// - rgb mode idle strap high gives eight colours
// - lc straps select black/white type one/two
// - filter strap equal order bit gives rgb
// - rgb mode display-off strap high blanks display
// - rgb mode invert strap high inverts data
// - source strap one scans from output 528
// - gate strap one scans lines in reverse
module strap_config_decoder (
  input wire logic hclk,
  input wire logic hresetn,
  // device reset pin, active low
  input wire logic reset_n,
  // configuration straps
  input wire logic bus_style_select,
  input wire logic interface_group_select,
  input wire logic bus_width_select_hi,
  input wire logic bus_width_select_lo,
  input wire logic extended_cmd_enable,
  input wire logic [1:0] line_count_select,
  input wire logic idle_color_strap,
  input wire logic [1:0] lc_type_select,
  input wire logic filter_order_strap,
  input wire logic display_off_strap,
  input wire logic data_invert_strap,
  input wire logic source_dir_strap,
  input wire logic gate_dir_strap,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // decoded settings
  output strap_pkg::host_if_t host_if,
  output strap_pkg::bus_width_t bus_width,
  output strap_pkg::line_count_t line_count,
  output logic lines_reserved,
  output logic [7:0] gate_lines,
  output logic [9:0] source_outputs,
  output strap_pkg::lc_type_t lc_type,
  output logic ext_cmd_allowed,
  output logic idle_8color,
  output logic filter_bgr,
  output logic display_on,
  output logic data_invert,
  output logic source_reverse,
  output logic gate_reverse,
  output logic settings_valid
);
  // settled strap vector and filter flag
  logic [`STRAP_W-1:0] strap_raw;
  logic [`STRAP_W-1:0] strap_stable;
  logic stable_seen;

  // software control: rgb mode and the memory access order bit
  logic [1:0] ctrl_reg, ctrl_next;
  // extended scratch word, only writable when extended access is open
  logic [31:0] ext_reg, ext_next;

  // ahb data-phase bookkeeping
  logic wr_pend_reg, wr_pend_next; // write data due this cycle
  logic [31:0] wr_addr_reg, wr_addr_next; // address of pending write
  logic [31:0] rdata_reg, rdata_next; // read data for data phase

  // combinational decode results
  strap_pkg::host_if_t d_host_if;
  strap_pkg::bus_width_t d_bus_width;
  strap_pkg::line_count_t d_line_count;
  strap_pkg::lc_type_t d_lc_type;
  logic d_lines_rsvd;
  logic [7:0] d_gate_lines;
  logic d_ext_ok;
  logic d_idle;
  logic d_filter_bgr;
  logic d_display_on;
  logic d_invert;
  logic d_src_rev;
  logic d_gate_rev;

  // registered settings
  strap_pkg::host_if_t host_if_reg, host_if_next;
  strap_pkg::bus_width_t bus_width_reg, bus_width_next;
  strap_pkg::line_count_t line_count_reg, line_count_next;
  strap_pkg::lc_type_t lc_type_reg, lc_type_next;
  logic [7:0] gate_lines_reg, gate_lines_next;
  logic [7:0] flags_reg, flags_next; // single-bit settings
  logic valid_reg, valid_next;

  // status word assembled from registered settings
  logic [31:0] status_word;
  // address phase qualifier
  logic addr_phase;

  // straps gathered in vector order
  assign strap_raw = {gate_dir_strap, source_dir_strap, data_invert_strap,
                      display_off_strap, filter_order_strap, lc_type_select,
                      idle_color_strap, line_count_select, extended_cmd_enable,
                      bus_width_select_hi, bus_width_select_lo,
                      interface_group_select, bus_style_select};

  // synchronise and settle every strap
  strap_sync_filter u_filter (
    .hclk(hclk),
    .hresetn(hresetn),
    .strap_in(strap_raw),
    .strap_stable(strap_stable),
    .stable_seen(stable_seen)
  );

  // decode settled straps with software control
  strap_field_decode u_decode (
    .sv(strap_stable),
    .rgb_mode(ctrl_reg[`CTRL_RGB_MODE]),
    .order_bit(ctrl_reg[`CTRL_ORDER_BIT]),
    .host_if(d_host_if),
    .bus_width(d_bus_width),
    .line_count(d_line_count),
    .lines_reserved(d_lines_rsvd),
    .gate_lines(d_gate_lines),
    .lc_type(d_lc_type),
    .ext_ok(d_ext_ok),
    .idle_8color(d_idle),
    .filter_bgr(d_filter_bgr),
    .display_on(d_display_on),
    .data_invert(d_invert),
    .source_reverse(d_src_rev),
    .gate_reverse(d_gate_rev)
  );

  // settings next values; device reset pin returns safe defaults
  always_comb begin
    if (!reset_n) begin
      host_if_next = strap_pkg::HOST_SERIAL3;
      bus_width_next = strap_pkg::WIDTH_8;
      line_count_next = strap_pkg::LINES_220;
      lc_type_next = strap_pkg::LC_NB1;
      gate_lines_next = `GATE_LINES_220;
      flags_next = 8'h04; // display on, rest off
      valid_next = 1'b0;
    end else if (stable_seen) begin
      host_if_next = d_host_if;
      bus_width_next = d_bus_width;
      line_count_next = d_line_count;
      lc_type_next = d_lc_type;
      gate_lines_next = d_gate_lines;
      flags_next = {d_lines_rsvd, d_ext_ok, d_gate_rev, d_src_rev, d_invert,
                    d_display_on, d_filter_bgr, d_idle};
      valid_next = 1'b1;
    end else begin
      // hold defaults until the first settled value
      host_if_next = host_if_reg;
      bus_width_next = bus_width_reg;
      line_count_next = line_count_reg;
      lc_type_next = lc_type_reg;
      gate_lines_next = gate_lines_reg;
      flags_next = flags_reg;
      valid_next = valid_reg;
    end
  end

  // settings registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      host_if_reg <= strap_pkg::HOST_SERIAL3;
      bus_width_reg <= strap_pkg::WIDTH_8;
      line_count_reg <= strap_pkg::LINES_220;
      lc_type_reg <= strap_pkg::LC_NB1;
      gate_lines_reg <= `GATE_LINES_220;
      flags_reg <= 8'h04;
      valid_reg <= 1'b0;
    end else begin
      host_if_reg <= host_if_next;
      bus_width_reg <= bus_width_next;
      line_count_reg <= line_count_next;
      lc_type_reg <= lc_type_next;
      gate_lines_reg <= gate_lines_next;
      flags_reg <= flags_next;
      valid_reg <= valid_next;
    end
  end

  // flags_reg bits: 0 idle, 1 bgr, 2 on, 3 invert, 4 src, 5 gate, 6 ext, 7 rsvd
  assign host_if = host_if_reg;
  assign bus_width = bus_width_reg;
  assign line_count = line_count_reg;
  assign lc_type = lc_type_reg;
  assign gate_lines = gate_lines_reg;
  assign source_outputs = `SOURCE_OUTPUTS;
  assign idle_8color = flags_reg[0];
  assign filter_bgr = flags_reg[1];
  assign display_on = flags_reg[2];
  assign data_invert = flags_reg[3];
  assign source_reverse = flags_reg[4];
  assign gate_reverse = flags_reg[5];
  assign ext_cmd_allowed = flags_reg[6];
  assign lines_reserved = flags_reg[7];
  assign settings_valid = valid_reg;

  // status word from registered settings
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_HOSTIF_MSB:`ST_HOSTIF_LSB] = host_if_reg;
    status_word[`ST_WIDTH_MSB:`ST_WIDTH_LSB] = bus_width_reg;
    status_word[`ST_LINES_MSB:`ST_LINES_LSB] = line_count_reg;
    status_word[`ST_LC_MSB:`ST_LC_LSB] = lc_type_reg;
    status_word[`ST_IDLE] = flags_reg[0];
    status_word[`ST_FILTER_BGR] = flags_reg[1];
    status_word[`ST_DISPLAY_ON] = flags_reg[2];
    status_word[`ST_INVERT] = flags_reg[3];
    status_word[`ST_SRC_REV] = flags_reg[4];
    status_word[`ST_GATE_REV] = flags_reg[5];
    status_word[`ST_EXT_OK] = flags_reg[6];
    status_word[`ST_LINES_RSVD] = flags_reg[7];
    status_word[`ST_GATE_MSB:`ST_GATE_LSB] = gate_lines_reg;
  end

  // valid transfer in address phase
  assign addr_phase = hsel & hready & (htrans == `HTRANS_NONSEQ | htrans == `HTRANS_SEQ);

  // bus next values: read data prepared at address phase, write at data phase
  always_comb begin
    ctrl_next = ctrl_reg;
    ext_next = ext_reg;
    wr_pend_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    rdata_next = 32'h0000_0000;
    // complete a pending write
    if (wr_pend_reg) begin
      if (wr_addr_reg == `OFS_CTRL) begin
        ctrl_next = hwdata[1:0];
      end else if (wr_addr_reg == `OFS_EXT) begin
        if (ext_cmd_allowed) begin
          ext_next = hwdata;
        end
      end
    end
    // accept a new address phase
    if (addr_phase) begin
      if (hwrite) begin
        wr_pend_next = 1'b1;
        wr_addr_next = {haddr[31:2], 2'h0};
      end else if ({haddr[31:2], 2'h0} == `OFS_CTRL) begin
        rdata_next = {30'h0000_0000, ctrl_next};
      end else if ({haddr[31:2], 2'h0} == `OFS_STATUS) begin
        rdata_next = status_word;
      end else if ({haddr[31:2], 2'h0} == `OFS_STRAPS) begin
        rdata_next = {17'h0_0000, strap_stable};
      end else if ({haddr[31:2], 2'h0} == `OFS_EXT) begin
        rdata_next = ext_cmd_allowed ? ext_next : 32'h0000_0000;
      end else begin
        rdata_next = 32'h0000_0000; // unmapped reads zero
      end
    end
    // device reset pin clears software state
    if (!reset_n) begin
      ctrl_next = `CTRL_RESET;
      ext_next = `EXT_RESET;
    end
  end

  // bus registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `CTRL_RESET;
      ext_reg <= `EXT_RESET;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 32'h0000_0000;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctrl_reg <= ctrl_next;
      ext_reg <= ext_next;
      wr_pend_reg <= wr_pend_next;
      wr_addr_reg <= wr_addr_next;
      rdata_reg <= rdata_next;
    end
  end

  // zero-wait slave, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_reg;
endmodule // strap_config_decoder
`default_nettype wire

// ==== pkg/strap_params.svh ====
`ifndef STRAP_CONFIG_PARAMS_SVH
`define STRAP_CONFIG_PARAMS_SVH

// clock and strap settling time
`define CLK_PERIOD_NS 50
`define STRAP_STABLE_NS 1000
`define STRAP_STABLE_CYC ((`STRAP_STABLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_CNT_W 5
`define STRAP_W 15

// strap vector bit positions
`define SV_BUS_STYLE 0
`define SV_IFACE_GROUP 1
`define SV_WIDTH_LO 2
`define SV_WIDTH_HI 3
`define SV_EXT_CMD 4
`define SV_LINES_LO 5
`define SV_LINES_HI 6
`define SV_IDLE 7
`define SV_LC_LO 8
`define SV_LC_HI 9
`define SV_FILTER 10
`define SV_DISP_OFF 11
`define SV_INVERT 12
`define SV_SRC_DIR 13
`define SV_GATE_DIR 14

// register byte offsets
`define OFS_CTRL 32'h0000_0000
`define OFS_STATUS 32'h0000_0004
`define OFS_STRAPS 32'h0000_0008
`define OFS_EXT 32'h0000_000C

// control register fields and reset value
`define CTRL_RGB_MODE 0
`define CTRL_ORDER_BIT 1
`define CTRL_RESET 2'h0
`define EXT_RESET 32'h0000_0000

// status register fields
`define ST_HOSTIF_LSB 0
`define ST_HOSTIF_MSB 1
`define ST_WIDTH_LSB 2
`define ST_WIDTH_MSB 3
`define ST_LINES_LSB 4
`define ST_LINES_MSB 5
`define ST_LC_LSB 6
`define ST_LC_MSB 7
`define ST_IDLE 8
`define ST_FILTER_BGR 9
`define ST_DISPLAY_ON 10
`define ST_INVERT 11
`define ST_SRC_REV 12
`define ST_GATE_REV 13
`define ST_EXT_OK 14
`define ST_LINES_RSVD 15
`define ST_GATE_LSB 16
`define ST_GATE_MSB 23

// panel geometry
`define GATE_LINES_220 8'hDC
`define GATE_LINES_176 8'hB0
`define GATE_LINES_132 8'h84
`define SOURCE_OUTPUTS 10'h210

// ahb-lite codes
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3
`define HSIZE_WORD 3'h2

`endif

// ==== pkg/strap_pkg.sv ====
`default_nettype none
package strap_pkg;
  // host interface selection
  typedef enum logic [1:0] {HOST_SERIAL3, HOST_PAR_SEP_STROBE, HOST_PAR_EN_STROBE} host_if_t;
  // parallel bus width, in strap code order
  typedef enum logic [1:0] {WIDTH_8, WIDTH_16, WIDTH_9, WIDTH_18} bus_width_t;
  // panel line count, in strap code order
  typedef enum logic [1:0] {LINES_220, LINES_176, LINES_RSVD, LINES_132} line_count_t;
  // liquid crystal type, in strap code order
  typedef enum logic [1:0] {LC_NB1, LC_NW1, LC_NB2, LC_NW2} lc_type_t;
  // settle filter states
  typedef enum logic {FILT_TRACK, FILT_HOLD} filt_state_t;
endpackage
`default_nettype wire

// ==== hw/strap_sync_filter.sv ====
`include "strap_params.svh"
`default_nettype none
// two-flop synchroniser per strap, then a settle counter on the whole vector
module strap_sync_filter (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [`STRAP_W-1:0] strap_in,
  output logic [`STRAP_W-1:0] strap_stable,
  output logic stable_seen
);
  logic [`STRAP_W-1:0] meta_reg; // first stage, read only by second
  logic [`STRAP_W-1:0] sync_reg; // second stage
  logic [`STRAP_W-1:0] last_reg, last_next; // value being timed
  logic [`STRAP_W-1:0] stable_reg, stable_next; // accepted value
  logic [`STRAP_CNT_W-1:0] cnt_reg, cnt_next; // cycles unchanged
  logic seen_reg, seen_next; // any value accepted yet
  strap_pkg::filt_state_t state_reg, state_next;

  // per-bit synchroniser; reset low so an open extended strap blocks
  genvar i;
  generate
    for (i = 0; i < `STRAP_W; i = i + 1) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          meta_reg[i] <= 1'b0;
          sync_reg[i] <= 1'b0;
        end else begin
          meta_reg[i] <= strap_in[i];
          sync_reg[i] <= meta_reg[i];
        end
      end
    end
  endgenerate

  // settle: accept only after the value held for the full count
  always_comb begin
    last_next = sync_reg;
    stable_next = stable_reg;
    cnt_next = cnt_reg;
    seen_next = seen_reg;
    state_next = state_reg;
    case (state_reg)
      strap_pkg::FILT_TRACK: begin
        if (sync_reg != last_reg) begin
          cnt_next = '0; // change restarts the wait
        end else if (cnt_reg == `STRAP_CNT_W'(`STRAP_STABLE_CYC - 1)) begin
          stable_next = sync_reg;
          seen_next = 1'b1;
          state_next = strap_pkg::FILT_HOLD;
        end else begin
          cnt_next = cnt_reg + `STRAP_CNT_W'(1);
        end
      end
      strap_pkg::FILT_HOLD: begin
        if (sync_reg != stable_reg) begin
          cnt_next = '0; // new value must settle again
          state_next = strap_pkg::FILT_TRACK;
        end
      end
      default: state_next = strap_pkg::FILT_TRACK;
    endcase
  end

  // filter registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last_reg <= '0;
      stable_reg <= '0;
      cnt_reg <= '0;
      seen_reg <= 1'b0;
      state_reg <= strap_pkg::FILT_TRACK;
    end else begin
      last_reg <= last_next;
      stable_reg <= stable_next;
      cnt_reg <= cnt_next;
      seen_reg <= seen_next;
      state_reg <= state_next;
    end
  end

  assign strap_stable = stable_reg;
  assign stable_seen = seen_reg;
endmodule // strap_sync_filter
`default_nettype wire

// ==== hw/strap_field_decode.sv ====
`include "strap_params.svh"
`default_nettype none
// pure decode of the settled strap vector into settings
module strap_field_decode (
  input wire logic [`STRAP_W-1:0] sv,
  input wire logic rgb_mode,
  input wire logic order_bit,
  output strap_pkg::host_if_t host_if,
  output strap_pkg::bus_width_t bus_width,
  output strap_pkg::line_count_t line_count,
  output logic lines_reserved,
  output logic [7:0] gate_lines,
  output strap_pkg::lc_type_t lc_type,
  output logic ext_ok,
  output logic idle_8color,
  output logic filter_bgr,
  output logic display_on,
  output logic data_invert,
  output logic source_reverse,
  output logic gate_reverse
);
  // decode
  always_comb begin
    if (!sv[`SV_IFACE_GROUP]) begin
      host_if = strap_pkg::HOST_SERIAL3;
      bus_width = strap_pkg::WIDTH_8; // width straps ignored
    end else begin
      host_if = sv[`SV_BUS_STYLE] ? strap_pkg::HOST_PAR_EN_STROBE
                                  : strap_pkg::HOST_PAR_SEP_STROBE;
      bus_width = strap_pkg::bus_width_t'({sv[`SV_WIDTH_HI], sv[`SV_WIDTH_LO]});
    end
    line_count = strap_pkg::line_count_t'({sv[`SV_LINES_HI], sv[`SV_LINES_LO]});
    lines_reserved = (line_count == strap_pkg::LINES_RSVD);
    if (line_count == strap_pkg::LINES_176) begin
      gate_lines = `GATE_LINES_176;
    end else if (line_count == strap_pkg::LINES_132) begin
      gate_lines = `GATE_LINES_132;
    end else begin
      gate_lines = `GATE_LINES_220; // reserved falls back to full height
    end
    lc_type = strap_pkg::lc_type_t'({sv[`SV_LC_HI], sv[`SV_LC_LO]});
    ext_ok = sv[`SV_EXT_CMD];
    idle_8color = rgb_mode & sv[`SV_IDLE];
    display_on = ~(rgb_mode & sv[`SV_DISP_OFF]);
    data_invert = rgb_mode & sv[`SV_INVERT];
    filter_bgr = sv[`SV_FILTER] ^ order_bit;
    source_reverse = sv[`SV_SRC_DIR];
    gate_reverse = sv[`SV_GATE_DIR];
  end
endmodule // strap_field_decode
`default_nettype wire

// ==== test/strap_decoder_asserts.sv ====
`default_nettype none
// watches decoded settings against the strap pins once they have settled
module strap_decoder_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reset_n,
  input wire logic bus_style_select,
  input wire logic interface_group_select,
  input wire logic bus_width_select_hi,
  input wire logic bus_width_select_lo,
  input wire logic extended_cmd_enable,
  input wire logic [1:0] line_count_select,
  input wire logic idle_color_strap,
  input wire logic [1:0] lc_type_select,
  input wire logic filter_order_strap,
  input wire logic display_off_strap,
  input wire logic data_invert_strap,
  input wire logic source_dir_strap,
  input wire logic gate_dir_strap,
  input wire strap_pkg::host_if_t host_if,
  input wire strap_pkg::bus_width_t bus_width,
  input wire strap_pkg::line_count_t line_count,
  input wire logic lines_reserved,
  input wire logic [7:0] gate_lines,
  input wire strap_pkg::lc_type_t lc_type,
  input wire logic ext_cmd_allowed,
  input wire logic idle_8color,
  input wire logic display_on,
  input wire logic data_invert,
  input wire logic source_reverse,
  input wire logic gate_reverse,
  input wire logic settings_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [14:0] sv_now; // raw strap pattern
  logic [14:0] sv_reg; // pattern one edge ago
  logic [5:0] cnt_reg; // edges since pattern moved
  logic [5:0] cnt_next;
  logic ok; // settled, valid, out of pin reset
  logic [7:0] exp_lines; // expected gate line count
  assign sv_now = {gate_dir_strap, source_dir_strap, data_invert_strap, display_off_strap,
    filter_order_strap, lc_type_select, idle_color_strap, line_count_select,
    extended_cmd_enable, bus_width_select_hi, bus_width_select_lo, interface_group_select,
    bus_style_select};
  // restart on any pin change, saturate at the top
  always_comb begin
    cnt_next = cnt_reg;
    if (sv_now != sv_reg) begin
      cnt_next = 6'h00;
    end else if (cnt_reg != 6'h3F) begin
      cnt_next = cnt_reg + 6'h01;
    end
  end
  // registers only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sv_reg <= 15'h0000;
      cnt_reg <= 6'h00;
    end else begin
      sv_reg <= sv_now;
      cnt_reg <= cnt_next;
    end
  end
  // margin above the synchroniser and settle latency
  assign ok = settings_valid && reset_n && (sv_now == sv_reg) && (cnt_reg >= 6'h1E);
  assign exp_lines = (line_count_select == 2'h1) ? 8'hB0 :
    ((line_count_select == 2'h3) ? 8'h84 : 8'hDC);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  serial_if_a: assert property (ok && !interface_group_select |-> host_if == 2'h0)
    else $error("serial host interface not selected");
  par_style_a: assert property (ok && interface_group_select |->
    host_if == (bus_style_select ? 2'h2 : 2'h1)) else $error("parallel strobe style wrong");
  bus_width_a: assert property (ok && interface_group_select |->
    bus_width == {bus_width_select_hi, bus_width_select_lo}) else $error("bus width wrong");
  pin_reset_a: assert property (!reset_n |=> !settings_valid && display_on && !gate_reverse)
    else $error("pin reset did not restore defaults");
  ext_gate_a: assert property (ok |-> ext_cmd_allowed == extended_cmd_enable)
    else $error("extended access does not follow strap");
  line_decode_a: assert property (ok |-> line_count == line_count_select &&
    lines_reserved == (line_count_select == 2'h2)) else $error("line code wrong");
  gate_count_a: assert property (ok |-> gate_lines == exp_lines)
    else $error("gate line count wrong");
  lc_decode_a: assert property (ok |-> lc_type == lc_type_select)
    else $error("liquid crystal type wrong");
  idle_gate_a: assert property (ok && idle_8color |-> idle_color_strap)
    else $error("idle colours without strap");
  disp_off_a: assert property (ok && !display_on |-> display_off_strap)
    else $error("display off without strap");
  invert_gate_a: assert property (ok && data_invert |-> data_invert_strap)
    else $error("inversion without strap");
  scan_dir_a: assert property (ok |-> source_reverse == source_dir_strap &&
    gate_reverse == gate_dir_strap) else $error("scan direction wrong");
  settle_time_a: assert property (reset_n && $past(reset_n) && $past(settings_valid) &&
    $changed({source_reverse, gate_reverse}) |-> cnt_reg >= 6'h14)
    else $error("setting moved before straps settled");
  cover property (ok && host_if == 2'h2);
  cover property (ok && idle_8color);
  cover property (!reset_n);
endmodule // strap_decoder_asserts
`default_nettype wire

// ==== test/strap_board.sv ====
`default_nettype none
// board straps and reset pin as the host side presents them
module strap_board (
  input wire logic [14:0] want,
  input wire logic ext_open,
  input wire logic rst_req,
  output logic reset_n,
  output logic bus_style_select,
  output logic interface_group_select,
  output logic bus_width_select_hi,
  output logic bus_width_select_lo,
  output logic extended_cmd_enable,
  output logic [1:0] line_count_select,
  output logic idle_color_strap,
  output logic [1:0] lc_type_select,
  output logic filter_order_strap,
  output logic display_off_strap,
  output logic data_invert_strap,
  output logic source_dir_strap,
  output logic gate_dir_strap
);
  timeunit 1ns;
  timeprecision 1ns;
  // host pulls the pin low to reset
  assign reset_n = !rst_req;
  // an open extended strap reads low
  assign extended_cmd_enable = ext_open ? 1'b0 : want[4];
  // the rest are plain levels
  assign {gate_dir_strap, source_dir_strap, data_invert_strap, display_off_strap} = want[14:11];
  assign {filter_order_strap, lc_type_select, idle_color_strap, line_count_select} = want[10:5];
  assign {bus_width_select_hi, bus_width_select_lo} = want[3:2];
  assign {interface_group_select, bus_style_select} = want[1:0];
endmodule // strap_board
`default_nettype wire

// ==== test/testbench.sv ====
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk = 1'b0, hresetn = 1'b0;
  logic [14:0] want = 15'h0000; // strap pattern on the board
  logic ext_open = 1'b1, rst_req = 1'b0;
  logic hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire logic hready, hreadyout, hresp;
  wire logic [31:0] hrdata;
  wire logic reset_n, bus_style_select, interface_group_select, bus_width_select_hi,
    bus_width_select_lo, extended_cmd_enable, idle_color_strap, filter_order_strap,
    display_off_strap, data_invert_strap, source_dir_strap, gate_dir_strap;
  wire logic [1:0] line_count_select, lc_type_select;
  strap_pkg::host_if_t host_if;
  strap_pkg::bus_width_t bus_width;
  strap_pkg::line_count_t line_count;
  strap_pkg::lc_type_t lc_type;
  logic lines_reserved, ext_cmd_allowed, idle_8color, filter_bgr, display_on, data_invert,
    source_reverse, gate_reverse, settings_valid;
  logic [7:0] gate_lines;
  logic [9:0] source_outputs;
  int miscompares = 0, total_checks = 0, cycles = 0;
  assign hready = hreadyout; // one slave on the bus
  strap_config_decoder DUT (.*);
  strap_board board (.*);
  always #25 hclk = ~hclk;
  // compare and count
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one single word transfer, read data into rd
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // new strap pattern, then wait past sync and settle
  task automatic put(input logic [14:0] v);
    @(posedge hclk);
    want <= v;
    repeat (30) @(posedge hclk);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  initial begin
    logic [14:0] v;
    repeat (2) @(posedge hclk);
    chk("valid_in_reset", 32'h0, settings_valid);
    chk("display_in_reset", 32'h1, display_on);
    hresetn <= 1'b1;
    // every interface code
    for (int i = 0; i < 16; i++) begin
      v = {11'h000, i[3:0]};
      put(v);
      chk("host_if", !v[1] ? 32'h0 : (v[0] ? 32'h2 : 32'h1), host_if);
      chk("bus_width", v[1] ? {30'h0, v[3:2]} : 32'h0, bus_width);
    end
    bus(1'b0, 32'h4, 32'h0);
    chk("status", 32'h00DC_040E, rd);
    chk("source_outputs", 32'h210, source_outputs);
    // line and liquid crystal codes, raw strap readback
    for (int i = 0; i < 4; i++) begin
      v = {5'h00, i[1:0], 1'b0, i[1:0], 5'h00};
      put(v);
      chk("line_count", i, line_count);
      chk("lines_reserved", i == 2, lines_reserved);
      chk("gate_lines", i == 1 ? 32'hB0 : (i == 3 ? 32'h84 : 32'hDC), gate_lines);
      chk("lc_type", i, lc_type);
      bus(1'b1, 32'h8, 32'hFFFF_FFFF);
      bus(1'b0, 32'h8, 32'h0);
      chk("straps_reg", {17'h0, v}, rd);
    end
    bus(1'b0, 32'h0, 32'h0);
    chk("ctrl_reset", 32'h0, rd);
    // rgb mode, order bit and strap level in all mixes
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 32'h0, {30'h0, i[2], i[0]});
      bus(1'b1, 32'h10, 32'hFFFF_FFFF);
      bus(1'b1, 32'h4, 32'hFFFF_FFFF);
      put({{5{i[1]}}, 2'h0, i[1], 7'h00});
      chk("idle_8color", i[0] & i[1], idle_8color);
      chk("display_on", !(i[0] & i[1]), display_on);
      chk("data_invert", i[0] & i[1], data_invert);
      chk("filter_bgr", i[1] ^ i[2], filter_bgr);
      chk("source_reverse", i[1], source_reverse);
      chk("gate_reverse", i[1], gate_reverse);
      bus(1'b0, 32'h0, 32'h0);
      chk("ctrl_reg", {30'h0, i[2], i[0]}, rd);
    end
    // open extended strap blocks the extended register
    put(15'h0010);
    chk("ext_open", 32'h0, ext_cmd_allowed);
    bus(1'b1, 32'hC, 32'hA5A5_5A5A);
    bus(1'b0, 32'hC, 32'h0);
    chk("ext_blocked", 32'h0, rd);
    ext_open <= 1'b0;
    put(15'h0010);
    chk("ext_allowed", 32'h1, ext_cmd_allowed);
    bus(1'b1, 32'hC, 32'hA5A5_5A5A);
    bus(1'b0, 32'hC, 32'h0);
    chk("ext_reg", 32'hA5A5_5A5A, rd);
    // short glitch on the direction straps is ignored
    @(posedge hclk);
    want <= 15'h6010;
    repeat (10) @(posedge hclk);
    want <= 15'h0010;
    repeat (30) @(posedge hclk);
    chk("glitch_gate", 32'h0, gate_reverse);
    chk("glitch_source", 32'h0, source_reverse);
    // pin reset in mid-run
    put(15'h4010);
    rst_req <= 1'b1;
    repeat (3) @(posedge hclk);
    chk("pin_reset_valid", 32'h0, settings_valid);
    chk("pin_reset_gate", 32'h0, gate_reverse);
    rst_req <= 1'b0;
    repeat (30) @(posedge hclk);
    chk("after_reset_gate", 32'h1, gate_reverse);
    bus(1'b0, 32'hC, 32'h0);
    chk("ext_after_reset", 32'h0, rd);
    give_verdict();
  end
endmodule // testbench
bind strap_config_decoder strap_decoder_asserts chk_i (.*);
`default_nettype wire
